// File: hdl/dsw_deep_sleep_watchdog.sv
/*
 * Deep sleep watchdog, its clock selection and the deep sleep status flag,
 * with an AHB-Lite register slave and one level interrupt.
 * Assumes rst is the true power-on reset and that the core raises
 * sleepCommand for one cycle when it executes its power-save instruction.
 */
// Function
// - Watchdog counts in deep sleep only when config bit 7 is set.
// - Watchdog runs without any dependence on the main watchdog.
// - Entering deep sleep clears the watchdog counter.
// - Config bit 4 selects the watchdog clock source.
// - Config bits 3:0 set the watchdog postscale ratio.
// - Timeouts span 2.1 ms shortest to 25.7 days longest.
// - Calendar and watchdog each use either oscillator, chosen separately, so both may run.
// - Config bit 5 selects the calendar clock source.
// - Enabled watchdog turns its clock on at entry if off.
// - Deep sleep flag, reset cause bit 10, sets on entry, software clears.
// - Flag pair decodes: other reset, normal power-on, deep sleep exit, or deep sleep flag alone.
// - True power-on reset clears all deep sleep logic.
// - Arm bit clears automatically on wake from deep sleep.
// - Deep sleep exit looks like a power-on reset to the core.
`timescale 1ns/1ps
`default_nettype none

module dsw_deep_sleep_watchdog
	import dsw_pkg::*;
(
	input  wire logic        core_clk,           // 100 MHz core clock
	input  wire logic        rst,                // Power-on reset, async, high
	input  wire logic        hsel,               // AHB slave select
	input  wire logic [31:0] haddr,              // AHB address
	input  wire logic [1:0]  htrans,             // AHB transfer type
	input  wire logic        hwrite,             // AHB write
	input  wire logic [2:0]  hsize,              // AHB size, word only
	input  wire logic        hready,             // AHB ready in
	input  wire logic [31:0] hwdata,             // AHB write data
	output logic      [31:0] hrdata,             // AHB read data
	output logic             hreadyout,          // AHB ready out
	output logic             hresp,              // AHB response
	input  wire logic        sleepCommand,       // Core power-save pulse
	input  wire logic        wakeEvent,          // Other wake source pulse
	input  wire logic        lowPowerRcClk,      // RC oscillator pin
	input  wire logic        secondaryOscClk,    // Secondary oscillator pin
	output logic             lowPowerRcEnable,   // RC oscillator on
	output logic             secondaryOscEnable, // Secondary oscillator on
	output logic             calendarClockSelect,// Calendar clock source
	output logic             deepSleepActive,    // In deep sleep
	output logic             coreResetRequest,   // Reset pulse to core on exit
	output dsw_pkg::dsw_cause_e resetCause,      // Decoded reset cause
	output logic             irq                 // Level interrupt
);
	import dsw_pkg::*;

	dsw_state_e       state;
	dsw_config_s      cfg;
	logic             arm;
	logic             swSoscOn;
	logic             swLprcOn;
	logic             deepSleepFlag;
	logic             powerOnFlag;
	logic [INT_W-1:0] intStatus;
	logic [INT_W-1:0] intMask;
	logic [INT_W-1:0] intEvent;
	logic [OSC_NUM-1:0] oscPins;
	logic [OSC_NUM-1:0] oscTick;
	logic             selTick;
	logic             enterSleep;
	logic             countEn;
	logic             wdtExpire;
	logic [CNT_W-1:0] wdtCount;
	logic             accept;
	logic             wrPending;
	logic [7:0]       wrAddr;
	logic [31:0]      readValue;
	logic [31:0]      causeWord;

	assign oscPins[OSC_LOW_POWER_RC_OSCILLATOR] = lowPowerRcClk;
	assign oscPins[OSC_SECONDARY_OSCILLATOR] = secondaryOscClk;

	// Oscillator pins are asynchronous to the core clock
	genvar gi;
	generate
		for (gi = 0; gi < OSC_NUM; gi++) begin : g_osc
			dsw_sync u_sync (
				.core_clk  (core_clk),
				.rst       (rst),
				.pinIn     (oscPins[gi]),
				.risePulse (oscTick[gi])
			);
		end
	endgenerate

	// No input from the main watchdog: this counter stands alone
	assign selTick = (cfg.wdtClockSelect == SEL_SECONDARY_OSCILLATOR) ? oscTick[OSC_SECONDARY_OSCILLATOR]
	                                                  : oscTick[OSC_LOW_POWER_RC_OSCILLATOR];
	assign enterSleep = (state == ST_ACTIVE) && sleepCommand && arm;
	assign countEn    = (state == ST_ASLEEP) && cfg.wdtEnable && selTick;

	dsw_counter u_counter (
		.core_clk  (core_clk),
		.rst       (rst),
		.clear     (enterSleep),
		.tickEn    (countEn),
		.postscale (cfg.postscale),
		.count     (wdtCount),
		.expired   (wdtExpire)
	);

	// Power-save state; an unarmed power-save request is ordinary sleep, not handled here
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= ST_ACTIVE;
		end else begin
			case (state)
				ST_ACTIVE: begin
					if (enterSleep) begin
						state <= ST_ASLEEP;
					end
				end
				ST_ASLEEP: begin
					if (wdtExpire || wakeEvent) begin
						state <= ST_EXIT;
					end
				end
				ST_EXIT: begin
					state <= ST_ACTIVE;
				end
				default: begin
					state <= ST_ACTIVE;
				end
			endcase
		end
	end

	assign coreResetRequest = (state == ST_EXIT);
	assign deepSleepActive  = (state == ST_ASLEEP);

	// In deep sleep an enabled watchdog forces its own oscillator on; the calendar always its selection
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lowPowerRcEnable    <= 1'b0;
			secondaryOscEnable  <= 1'b0;
			calendarClockSelect <= SEL_LOW_POWER_RC_OSCILLATOR;
		end else begin
			calendarClockSelect <= cfg.calendarSelect;
			lowPowerRcEnable <= swLprcOn
				|| (cfg.calendarSelect == SEL_LOW_POWER_RC_OSCILLATOR)
				|| (deepSleepActive && cfg.wdtEnable
				    && cfg.wdtClockSelect == SEL_LOW_POWER_RC_OSCILLATOR);
			secondaryOscEnable <= swSoscOn
				|| (cfg.calendarSelect == SEL_SECONDARY_OSCILLATOR)
				|| (deepSleepActive && cfg.wdtEnable
				    && cfg.wdtClockSelect == SEL_SECONDARY_OSCILLATOR);
		end
	end

	// Bus slave: zero wait states, read data registered into the data phase
	assign accept    = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;

	assign causeWord = (32'(deepSleepFlag) << RC_DS_FLAG_BIT)
	                 | (32'(powerOnFlag) << RC_POR_BIT);

	always_comb begin
		case (haddr[7:0])
			OFS_CONFIG:      readValue = {24'h000000, cfg};
			OFS_CONTROL:     readValue = {29'h00000000, swLprcOn, swSoscOn, arm};
			OFS_RESET_CAUSE: readValue = causeWord;
			OFS_COUNT:       readValue = wdtCount[31:0];
			OFS_STATE:       readValue = {31'h00000000, deepSleepActive};
			OFS_INT_STATUS:  readValue = {29'h00000000, intStatus};
			OFS_INT_MASK:    readValue = {29'h00000000, intMask};
			default:         readValue = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPending <= 1'b0;
			wrAddr    <= 8'h00;
			hrdata    <= 32'h00000000;
		end else begin
			wrPending <= accept && hwrite;
			wrAddr    <= haddr[7:0];
			hrdata    <= (accept && !hwrite) ? readValue : 32'h00000000;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg     <= CONFIG_RESET;
			intMask <= '0;
		end else if (wrPending) begin
			if (wrAddr == OFS_CONFIG) begin
				cfg <= hwdata[7:0];
			end
			if (wrAddr == OFS_INT_MASK) begin
				intMask <= hwdata[INT_W-1:0];
			end
		end
	end

	// Wake clears arm even against a same-cycle software write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arm      <= 1'b0;
			swSoscOn <= 1'b0;
			swLprcOn <= 1'b0;
		end else begin
			if (wrPending && wrAddr == OFS_CONTROL) begin
				swSoscOn <= hwdata[CTL_SECONDARY_OSCILLATOR_BIT];
				swLprcOn <= hwdata[CTL_LOW_POWER_RC_OSCILLATOR_BIT];
			end
			if (state == ST_EXIT) begin
				arm <= 1'b0;
			end else if (wrPending && wrAddr == OFS_CONTROL) begin
				arm <= hwdata[CTL_ARM_BIT];
			end
		end
	end

	// Flags clear by writing zero; a same-cycle entry still sets
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			deepSleepFlag <= 1'b0;
			powerOnFlag   <= 1'b1;
		end else begin
			if (enterSleep) begin
				deepSleepFlag <= 1'b1;
			end else if (wrPending && wrAddr == OFS_RESET_CAUSE) begin
				deepSleepFlag <= deepSleepFlag & hwdata[RC_DS_FLAG_BIT];
			end
			if (wrPending && wrAddr == OFS_RESET_CAUSE) begin
				powerOnFlag <= powerOnFlag & hwdata[RC_POR_BIT];
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			resetCause <= CAUSE_OTHER;
		end else begin
			case ({deepSleepFlag, powerOnFlag})
				2'b01:   resetCause <= CAUSE_POR;
				2'b11:   resetCause <= CAUSE_DS_EXIT;
				2'b10:   resetCause <= CAUSE_DS_ONLY;
				default: resetCause <= CAUSE_OTHER;
			endcase
		end
	end

	assign intEvent[INT_ENTRY]   = enterSleep;
	assign intEvent[INT_TIMEOUT] = wdtExpire && deepSleepActive;
	assign intEvent[INT_WAKE]    = (state == ST_EXIT);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			intStatus <= '0;
		end else if (wrPending && wrAddr == OFS_INT_STATUS) begin
			intStatus <= (intStatus & ~hwdata[INT_W-1:0]) | intEvent;
		end else begin
			intStatus <= intStatus | intEvent;
		end
	end

	assign irq = |(intStatus & intMask);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_disabled_holds;
		(!cfg.wdtEnable && !enterSleep) |=> $stable(wdtCount);
	endproperty
	a_disabled_holds: assert property (p_disabled_holds)
		else $error("counter moved while watchdog disabled");

	property p_entry_clears;
		enterSleep |=> (wdtCount == '0);
	endproperty
	a_entry_clears: assert property (p_entry_clears)
		else $error("counter not cleared on deep sleep entry");

	property p_unselected_idle;
		(deepSleepActive && !selTick && !enterSleep) |=> $stable(wdtCount);
	endproperty
	a_unselected_idle: assert property (p_unselected_idle)
		else $error("counter advanced without selected clock tick");

	property p_flag_on_entry;
		enterSleep |=> (deepSleepFlag && deepSleepActive);
	endproperty
	a_flag_on_entry: assert property (p_flag_on_entry)
		else $error("deep sleep flag not set on entry");

	property p_arm_cleared;
		(state == ST_EXIT) |=> !arm;
	endproperty
	a_arm_cleared: assert property (p_arm_cleared)
		else $error("arm bit survived wake");

	property p_reset_pulse;
		coreResetRequest |=> (!coreResetRequest && state == ST_ACTIVE);
	endproperty
	a_reset_pulse: assert property (p_reset_pulse)
		else $error("core reset request not a single pulse");

	property p_timeout_wakes;
		(wdtExpire && deepSleepActive) |=> coreResetRequest;
	endproperty
	a_timeout_wakes: assert property (p_timeout_wakes)
		else $error("timeout did not end deep sleep");

	property p_clock_forced;
		(deepSleepActive && cfg.wdtEnable && cfg.wdtClockSelect == SEL_SECONDARY_OSCILLATOR)[*2]
			|-> secondaryOscEnable;
	endproperty
	a_clock_forced: assert property (p_clock_forced)
		else $error("watchdog clock not turned on in deep sleep");

	property p_cause_decode;
		(deepSleepFlag && powerOnFlag)[*2] |-> (resetCause == CAUSE_DS_EXIT);
	endproperty
	a_cause_decode: assert property (p_cause_decode)
		else $error("reset cause decode wrong");

	c_timeout_exit: cover property (wdtExpire && deepSleepActive ##1 coreResetRequest);
	c_wake_exit: cover property (deepSleepActive && wakeEvent && !wdtExpire);
	c_flag_clear: cover property (deepSleepFlag ##1 !deepSleepFlag);
	c_irq: cover property ($rose(irq));

endmodule : dsw_deep_sleep_watchdog
`default_nettype wire

// File: hdl/dsw_pkg.sv
/*
 * Shared constants, register map, field layouts and types of the deep sleep
 * watchdog block. Assumes a 32-bit AHB-Lite register bus and a single
 * 100 MHz core clock.
 */
package dsw_pkg;

	// Core clock
	localparam int unsigned CORE_CLK_HZ = 100_000_000;

	// Register byte offsets (word aligned)
	localparam logic [7:0] OFS_CONFIG      = 8'h00;
	localparam logic [7:0] OFS_CONTROL     = 8'h04;
	localparam logic [7:0] OFS_RESET_CAUSE = 8'h08;
	localparam logic [7:0] OFS_COUNT       = 8'h0C;
	localparam logic [7:0] OFS_STATE       = 8'h10;
	localparam logic [7:0] OFS_INT_STATUS  = 8'h14;
	localparam logic [7:0] OFS_INT_MASK    = 8'h18;

	// Deep sleep configuration word: bit 7 enable, 5 calendar clock, 4 watchdog clock, 3:0 ratio
	typedef struct packed {
		logic       wdtEnable;
		logic       unused6;
		logic       calendarSelect;
		logic       wdtClockSelect;
		logic [3:0] postscale;
	} dsw_config_s;
	localparam logic [7:0] CONFIG_RESET = 8'h00;

	// Clock select encoding and oscillator indices
	localparam logic SEL_LOW_POWER_RC_OSCILLATOR = 1'b0;
	localparam logic SEL_SECONDARY_OSCILLATOR = 1'b1;
	localparam int   OSC_NUM  = 2;
	localparam int   OSC_LOW_POWER_RC_OSCILLATOR = 0;
	localparam int   OSC_SECONDARY_OSCILLATOR = 1;

	// Control register bits
	localparam int CTL_ARM_BIT  = 0;
	localparam int CTL_SECONDARY_OSCILLATOR_BIT = 1;
	localparam int CTL_LOW_POWER_RC_OSCILLATOR_BIT = 2;

	// Reset cause register bits
	localparam int RC_DS_FLAG_BIT = 10;
	localparam int RC_POR_BIT     = 0;

	// Interrupt status / mask layout
	localparam int INT_W       = 3;
	localparam int INT_ENTRY   = 0;
	localparam int INT_TIMEOUT = 1;
	localparam int INT_WAKE    = 2;

	// Timeout span: 2.1 ms shortest, 25.7 days longest at the RC oscillator
	localparam int unsigned TIMEOUT_MIN_US       = 2100;
	localparam int unsigned TIMEOUT_MAX_DAYS_X10 = 257;
	// 2^6 ticks at the low-power RC give the shortest period, each step quadruples it
	localparam logic [5:0] TIMEOUT_EXP_BASE = 6'h06;
	localparam int         CNT_W            = 37;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

	typedef enum logic [1:0] {
		CAUSE_OTHER,
		CAUSE_POR,
		CAUSE_DS_EXIT,
		CAUSE_DS_ONLY
	} dsw_cause_e;

	typedef enum {
		ST_ACTIVE,
		ST_ASLEEP,
		ST_EXIT
	} dsw_state_e;

endpackage : dsw_pkg

// File: hdl/dsw_sync.sv
/*
 * Three-stage synchroniser for one free-running oscillator pin, giving a
 * one-cycle pulse per rising edge. Assumes the oscillator is far slower
 * than core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module dsw_sync (
	input  wire logic core_clk, // Core clock
	input  wire logic rst,      // Async reset, active high
	input  wire logic pinIn,    // Raw oscillator pin
	output logic      risePulse // One cycle per rising edge
);
	logic stage1;
	logic stage2;
	logic stage3;
	logic level;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A change counts only once the second and third stages agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			level     <= 1'b0;
			risePulse <= 1'b0;
		end else begin
			risePulse <= (stage2 == stage3) && stage3 && !level;
			if (stage2 == stage3) begin
				level <= stage3;
			end
		end
	end

endmodule : dsw_sync
`default_nettype wire

// File: hdl/dsw_counter.sv
/*
 * Deep sleep watchdog counter with selectable power-of-four timeout.
 * Assumes tickEn is a one-cycle pulse per oscillator edge.
 */
`timescale 1ns/1ps
`default_nettype none

module dsw_counter
	import dsw_pkg::*;
(
	input  wire logic             core_clk,  // Core clock
	input  wire logic             rst,       // Async reset, active high
	input  wire logic             clear,     // Restart from zero
	input  wire logic             tickEn,    // Selected oscillator tick
	input  wire logic [3:0]       postscale, // Timeout ratio select
	output logic [dsw_pkg::CNT_W-1:0] count, // Current count
	output logic                  expired    // One-cycle timeout pulse
);
	logic [5:0]       exponent;
	logic [CNT_W-1:0] terminal;
	logic             atEnd;

	assign exponent = TIMEOUT_EXP_BASE + {1'b0, postscale, 1'b0};
	assign terminal = (CNT_W'(1) << exponent) - CNT_W'(1);
	assign atEnd    = (count == terminal);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count   <= '0;
			expired <= 1'b0;
		end else begin
			expired <= !clear && tickEn && atEnd;
			if (clear) begin
				count <= '0;
			end else if (tickEn) begin
				count <= atEnd ? '0 : count + CNT_W'(1);
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_terminal_expire;
		(tickEn && !clear && atEnd) |=> (expired && count == '0);
	endproperty
	a_terminal_expire: assert property (p_terminal_expire)
		else $error("timeout did not fire at terminal count");

endmodule : dsw_counter
`default_nettype wire

// File: verification/dsw_testbench.sv
/*
 * Self-checking bench for the deep sleep watchdog block: register access,
 * sleep entry, wake by timeout and by event, interrupt, reset cause flags.
 * Assumes a zero-wait AHB-Lite slave and one 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import dsw_pkg::*;

	logic        core_clk, rst, hsel, hwrite, sleepCommand, wakeEvent;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, lowPowerRcClk, secondaryOscClk;
	logic        lowPowerRcEnable, secondaryOscEnable, calendarClockSelect;
	logic        deepSleepActive, coreResetRequest, irq, rdPhase;
	dsw_cause_e  resetCause;
	wire logic   hready;
	logic [31:0] expQ[$], maskQ[$], cfg;
	int          n_errors, n_checks, ticks, cyc, div, n, seed;

	assign hready = hreadyout;

	dsw_deep_sleep_watchdog dsw_deep_sleep_watchdog_i (
		.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sleepCommand(sleepCommand), .wakeEvent(wakeEvent),
		.lowPowerRcClk(lowPowerRcClk), .secondaryOscClk(secondaryOscClk),
		.lowPowerRcEnable(lowPowerRcEnable), .secondaryOscEnable(secondaryOscEnable),
		.calendarClockSelect(calendarClockSelect), .deepSleepActive(deepSleepActive),
		.coreResetRequest(coreResetRequest), .resetCause(resetCause), .irq(irq)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			n_errors++;
		end
	endtask : chk

	task automatic results();
		$display("checks=%0d mismatches=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	// Called just after a rising edge; returns just after the data phase edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {24'h000000, a};
		hwrite <= 1'b1;
		do @(posedge core_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {24'h000000, a};
		hwrite <= 1'b0;
		do @(posedge core_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		rdPhase <= 1'b1;
		expQ.push_back(e & m);
		maskQ.push_back(m);
		do @(posedge core_clk); while (hready !== 1'b1);
		rdPhase <= 1'b0;
	endtask : rd

	// Read data are judged by this watcher, in the data phase's closing edge
	always @(posedge core_clk) begin
		if (rdPhase)
			chk(hrdata & maskQ.pop_front(), expQ.pop_front());
	end

	task automatic pulse(input logic sel);
		if (sel)
			wakeEvent <= 1'b1;
		else
			sleepCommand <= 1'b1;
		@(posedge core_clk);
		wakeEvent    <= 1'b0;
		sleepCommand <= 1'b0;
	endtask : pulse

	task automatic waitExit(input int lim, output int cycles);
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (coreResetRequest !== 1'b1 && k < lim);
		chk({31'h0, coreResetRequest}, 32'h1);
		cycles = cyc;
	endtask : waitExit

	task automatic tdone(input string name);
		$display("test %0s done", name);
	endtask : tdone

	// Oscillators toggle every 5 cycles only while enabled, a stopped one holds
	always @(posedge core_clk) begin
		div <= (div == 4) ? 0 : div + 1;
		if (div == 4 && lowPowerRcEnable === 1'b1)
			lowPowerRcClk <= ~lowPowerRcClk;
		if (div == 4 && secondaryOscEnable === 1'b1)
			secondaryOscClk <= ~secondaryOscClk;
		cyc <= sleepCommand ? 0 : cyc + 1;
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			n_errors++;
			results();
		end
	end

	initial begin
		seed = 32'h7ED8548D;
		{rst, hsel, hwrite, sleepCommand, wakeEvent, rdPhase} = 6'h20;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		{lowPowerRcClk, secondaryOscClk} = 2'h0;
		{n_errors, n_checks, ticks, cyc, div} = '0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(OFS_CONFIG, 32'h0, '1);
		rd(OFS_CONTROL, 32'h0, '1);
		rd(OFS_RESET_CAUSE, 32'h1, '1);
		rd(OFS_STATE, 32'h0, '1);
		rd(OFS_INT_STATUS, 32'h0, '1);
		rd(8'h1C, 32'h0, '1);
		@(negedge core_clk);
		chk({30'h0, resetCause}, {30'h0, CAUSE_POR});
		chk({29'h0, lowPowerRcEnable, secondaryOscEnable, hresp}, 32'h4);
		@(posedge core_clk);
		tdone("reset");
		repeat (4) begin
			cfg = $random(seed);
			wr(OFS_CONFIG, cfg);
			rd(OFS_CONFIG, cfg, 32'hBF);
			@(negedge core_clk);
			chk({31'h0, calendarClockSelect}, {31'h0, cfg[5]});
			chk({30'h0, secondaryOscEnable, lowPowerRcEnable}, {30'h0, cfg[5], !cfg[5]});
			@(posedge core_clk);
		end
		tdone("config");
		wr(OFS_CONFIG, 32'hA0);
		pulse(1'b0);
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk({30'h0, deepSleepActive, lowPowerRcEnable}, 32'h0);
		@(posedge core_clk);
		tdone("unarmed");
		wr(OFS_INT_MASK, 32'h7);
		wr(OFS_CONTROL, 32'h1);
		pulse(1'b0);
		// Oscillator enables are registered from the asleep state, one cycle behind it
		@(posedge core_clk);
		@(negedge core_clk);
		chk({29'h0, deepSleepActive, lowPowerRcEnable, irq}, 32'h7);
		@(posedge core_clk);
		rd(OFS_RESET_CAUSE, 32'h401, '1);
		rd(OFS_STATE, 32'h1, 32'h1);
		repeat (200 + ($unsigned($random(seed)) % 150)) @(posedge core_clk);
		pulse(1'b1);
		waitExit(8, n);
		rd(OFS_INT_STATUS, 32'h5, 32'h7);
		rd(OFS_CONTROL, 32'h0, 32'h1);
		@(negedge core_clk);
		chk({30'h0, resetCause}, {30'h0, CAUSE_DS_EXIT});
		@(posedge core_clk);
		tdone("event wake");
		wr(OFS_INT_STATUS, 32'h7);
		wr(OFS_CONTROL, 32'h1);
		pulse(1'b0);
		waitExit(800, n);
		chk({31'h0, n >= 620 && n <= 700}, 32'h1);
		rd(OFS_INT_STATUS, 32'h7, 32'h7);
		tdone("timeout rc");
		wr(OFS_INT_STATUS, 32'h7);
		wr(OFS_CONFIG, 32'hB1);
		wr(OFS_CONTROL, 32'h3);
		pulse(1'b0);
		@(negedge core_clk);
		chk({30'h0, secondaryOscEnable, lowPowerRcEnable}, 32'h2);
		@(posedge core_clk);
		waitExit(3000, n);
		chk({31'h0, n >= 2540 && n <= 2620}, 32'h1);
		rd(OFS_CONTROL, 32'h2, 32'h7);
		tdone("timeout secondary");
		wr(OFS_INT_STATUS, 32'h7);
		wr(OFS_CONFIG, 32'h20);
		wr(OFS_CONTROL, 32'h1);
		pulse(1'b0);
		repeat (3000) @(posedge core_clk);
		@(negedge core_clk);
		chk({30'h0, deepSleepActive, lowPowerRcEnable}, 32'h2);
		@(posedge core_clk);
		rd(OFS_COUNT, 32'h0, '1);
		pulse(1'b1);
		waitExit(8, n);
		tdone("disabled");
		wr(OFS_INT_MASK, 32'h0);
		@(negedge core_clk);
		chk({31'h0, irq}, 32'h0);
		@(posedge core_clk);
		wr(OFS_INT_MASK, 32'h4);
		@(negedge core_clk);
		chk({31'h0, irq}, 32'h1);
		@(posedge core_clk);
		wr(OFS_INT_STATUS, 32'h4);
		@(negedge core_clk);
		chk({31'h0, irq}, 32'h0);
		@(posedge core_clk);
		tdone("interrupt");
		rd(OFS_RESET_CAUSE, 32'h401, '1);
		wr(OFS_RESET_CAUSE, 32'h1);
		rd(OFS_RESET_CAUSE, 32'h1, '1);
		@(negedge core_clk);
		chk({30'h0, resetCause}, {30'h0, CAUSE_POR});
		@(posedge core_clk);
		wr(OFS_RESET_CAUSE, 32'h0);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk({30'h0, resetCause}, {30'h0, CAUSE_OTHER});
		@(posedge core_clk);
		// Deep sleep flag alone, power-on flag already cleared
		wr(OFS_CONTROL, 32'h1);
		pulse(1'b0);
		@(posedge core_clk);
		@(negedge core_clk);
		chk({30'h0, resetCause}, {30'h0, CAUSE_DS_ONLY});
		@(posedge core_clk);
		pulse(1'b1);
		waitExit(8, n);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(OFS_CONFIG, 32'h0, '1);
		rd(OFS_RESET_CAUSE, 32'h1, '1);
		tdone("flags and power-on");
		results();
	end
endmodule : testbench

`default_nettype wire
